// ### core/range_select_decode.sv
// Decodes the live mode/range select pair into mode and range
`timescale 1ns/100ps
module range_select_decode
  import strap_pkg::*;
(
  // Strap pins
  input  wire logic       mode_range_select_hi,
  input  wire logic       mode_range_select_lo,
  // Decoded
  output logic            live_hw_mode,
  output logic [1:0]      live_range
);

  logic [1:0] mode_range_select_pair;

  assign mode_range_select_pair = {mode_range_select_hi, mode_range_select_lo};
  assign live_hw_mode           = is_hw_mode(mode_range_select_pair); // R11 R12
  // Codes 01, 10, 11 map straight onto smallest, middle, largest range
  assign live_range             = mode_range_select_pair;             // R12

endmodule : range_select_decode

// ### core/reset_pulse_classifier.sv
// Measures low pulses on the reset pin and classifies them on release
`timescale 1ns/100ps
module reset_pulse_classifier
  import strap_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Reset pin
  input  wire logic reset_pin_b,
  // Classification
  output logic      pin_low,
  output logic      full_pulse,
  output logic      partial_pulse
);

  logic [CNT_W-1:0] low_cnt_reg;
  logic             prev_reg;
  logic             rise;
  logic             long_enough;
  logic             short_ok;

  assign rise        = reset_pin_b && !prev_reg;
  assign long_enough = low_cnt_reg >= CNT_W'(FULL_CYC);   // R4
  assign short_ok    = low_cnt_reg >= CNT_W'(PARTIAL_CYC); // R4

  // Counter saturates at the full threshold so it never wraps
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      low_cnt_reg   <= '0;
      prev_reg      <= 1'b1;
      pin_low       <= 1'b0;
      full_pulse    <= 1'b0;
      partial_pulse <= 1'b0;
    end else begin
      prev_reg      <= reset_pin_b;
      pin_low       <= !reset_pin_b;
      full_pulse    <= rise && long_enough;              // R4
      partial_pulse <= rise && short_ok && !long_enough; // R4
      if (reset_pin_b)
        low_cnt_reg <= '0;
      else if (!long_enough)
        low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end

endmodule : reset_pulse_classifier

// ### core/strap_latch_reset_control.sv
// Strap latching, reset-pin decoding and configuration registers
// Function
// [R1] Reference select high: enable internal reference, drive it out on reference pin.
// [R2] Reference select low: internal reference off, reference pin is an input.
// [R3] Reference select captured at full reset release, ignored afterwards.
// [R4] Each low reset pulse classified full or partial by its length; pulses under PARTIAL_CYC cycles are dropped unclassified.
// [R5] Device stays in shutdown while the reset pin is held low.
// [R6] Hardware mode: sequencer strap low disables, high enables with reduced features.
// [R7] Sequencer strap latched at full reset release, later changes ignored.
// [R8] Software mode: outside party ties sequencer strap to digital ground.
// [R9] Hardware/software mode latched at full reset, fixed until next one.
// [R10] Hardware mode range follows the select pins live, never latched.
// [R11] Select pair 00 gives software mode, configured through registers.
// [R12] Codes 01, 10, 11 select smallest, middle, largest fixed range.
`timescale 1ns/100ps
module strap_latch_reset_control
  import strap_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Reset pin and straps
  input  wire logic              reset_pin_b,
  input  wire logic              reference_source_select,
  input  wire logic              sequencer_enable_strap,
  input  wire logic              mode_range_select_hi,
  input  wire logic              mode_range_select_lo,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Reference control
  output logic                   internal_ref_enable,
  output logic                   reference_io_pin_oe_b,
  // Sequencer control
  output logic                   sequencer_enable,
  output logic                   sequencer_limited,
  // Mode and range
  output logic                   hw_mode,
  output logic      [1:0]        input_range,
  // Reset status
  output logic                   shutdown,
  output logic                   full_reset_pulse,
  output logic                   partial_reset_pulse,
  output logic                   config_ready
);

  dev_state_t        state_reg;
  dev_state_t        state_next;
  logic              pin_low;
  logic              full_pulse;
  logic              partial_pulse;
  logic              live_hw_mode;
  logic [1:0]        live_range;
  logic              capture;
  logic              ref_sel_reg;
  logic              seq_strap_reg;
  logic              hw_mode_reg;
  logic              ready_reg;
  logic [DATA_W-1:0] control_reg;
  logic [EV_W-1:0]   events_reg;
  logic [EV_W-1:0]   events_set;
  logic [EV_W-1:0]   events_clr;
  logic [CNT_W-1:0]  full_cnt_reg;
  logic [CNT_W-1:0]  part_cnt_reg;
  logic              in_shutdown;
  logic              wr_control;
  logic              wr_events;
  logic              rd_hit;
  logic [DATA_W-1:0] rd_value;
  logic [DATA_W-1:0] status_word;
  logic [1:0]        range_next;
  logic              seq_en_next;
  logic              seq_lim_next;
  logic              ref_en_next;
  logic              ready_next;
  logic              hit_status;
  logic              hit_control;
  logic              hit_events;
  logic              hit_full_cnt;
  logic              hit_part_cnt;

  reset_pulse_classifier u_classifier (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .reset_pin_b   (reset_pin_b),
    .pin_low       (pin_low),
    .full_pulse    (full_pulse),
    .partial_pulse (partial_pulse)
  );

  range_select_decode u_decode (
    .mode_range_select_hi (mode_range_select_hi),
    .mode_range_select_lo (mode_range_select_lo),
    .live_hw_mode         (live_hw_mode),
    .live_range           (live_range)
  );

  // Device state: boot capture, running, reset pin low
  always_comb begin
    state_next = state_reg;
    capture    = 1'b0;
    case (state_reg)
      ST_BOOT: begin
        if (!reset_pin_b) begin
          state_next = ST_LOW;
        end else begin
          capture    = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pin_low)
          state_next = ST_LOW;
      end
      ST_LOW: begin
        // Too-short pulses are dropped: back to run, nothing relatched
        if (full_pulse) begin
          capture    = 1'b1; // R3 R7 R9
          state_next = ST_RUN;
        end else if (partial_pulse || !pin_low) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_BOOT;
    endcase
  end

  assign in_shutdown = pin_low || (state_reg == ST_LOW); // R5

  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      state_reg <= ST_BOOT;
    else
      state_reg <= state_next;
  end

  // Straps are sampled only on capture; later pin changes have no effect
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ref_sel_reg   <= 1'b0;
      seq_strap_reg <= 1'b0;
      hw_mode_reg   <= 1'b0;
    end else if (capture) begin
      ref_sel_reg   <= reference_source_select; // R3
      seq_strap_reg <= sequencer_enable_strap;  // R7
      hw_mode_reg   <= live_hw_mode;            // R9
    end
  end

  // Ready stays up across later resets; only the system reset clears it
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      ready_reg <= 1'b0;
    else if (capture)
      ready_reg <= 1'b1;
  end

  // Register decode, one hit per mapped offset
  assign hit_status   = (reg_addr == OFF_STATUS);
  assign hit_control  = (reg_addr == OFF_CONTROL);
  assign hit_events   = (reg_addr == OFF_EVENTS);
  assign hit_full_cnt = (reg_addr == OFF_FULL_CNT);
  assign hit_part_cnt = (reg_addr == OFF_PART_CNT);
  // Configuration writes are refused while the device sits in shutdown
  assign wr_control   = reg_wr && !in_shutdown && hit_control;
  assign wr_events    = reg_wr && hit_events;

  // Software configuration is lost on every full reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      control_reg <= CONTROL_RESET;
    else if (full_pulse)
      control_reg <= CONTROL_RESET;
    else if (wr_control)
      control_reg <= reg_wdata;
  end

  // Sticky events, a set in the clearing cycle wins
  assign events_set[EV_STRAP_BIT] = ready_reg && !hw_mode_reg && sequencer_enable_strap; // R8
  assign events_set[EV_FULL_BIT]  = full_pulse;
  assign events_set[EV_PART_BIT]  = partial_pulse;
  assign events_clr = wr_events ? reg_wdata[EV_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      events_reg <= '0;
    else
      events_reg <= (events_reg & ~events_clr) | events_set;
  end

  // Reset counters survive full resets; only the system reset clears them
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      full_cnt_reg <= '0;
    else if (full_pulse)
      full_cnt_reg <= sat_inc(full_cnt_reg);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      part_cnt_reg <= '0;
    else if (partial_pulse)
      part_cnt_reg <= sat_inc(part_cnt_reg);
  end

  // Active configuration
  // Hardware range tracks the pins, software range comes from CONTROL
  assign range_next = hw_mode_reg ? live_range                                   // R10 R12
                                  : control_reg[CT_RANGE_LSB +: 2];             // R11
  assign seq_en_next  = !in_shutdown && (hw_mode_reg ? seq_strap_reg             // R6
                                                     : control_reg[CT_SEQ_BIT]); // R11
  assign seq_lim_next = !in_shutdown && hw_mode_reg && seq_strap_reg;            // R6
  // Reference is powered down in shutdown
  assign ref_en_next  = !in_shutdown && ready_reg && ref_sel_reg;                // R1 R2
  assign ready_next   = ready_reg && !in_shutdown;

  // Pin enable is the inverse of the reference enable, both from one flop stage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      internal_ref_enable   <= 1'b0;
      reference_io_pin_oe_b <= 1'b1;
    end else begin
      internal_ref_enable   <= ref_en_next;  // R1 R2
      reference_io_pin_oe_b <= !ref_en_next; // R1 R2
    end
  end

  // Sequencer is forced off in shutdown whatever the mode
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sequencer_enable  <= 1'b0;
      sequencer_limited <= 1'b0;
    end else begin
      sequencer_enable  <= seq_en_next;  // R6
      sequencer_limited <= seq_lim_next; // R6
    end
  end

  // Mode output lags the captured mode by one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hw_mode     <= 1'b0;
      input_range <= RANGE_10V;
    end else begin
      hw_mode     <= hw_mode_reg; // R9
      input_range <= range_next;  // R10
    end
  end

  // Reset status follows the pin decode one cycle later
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shutdown            <= 1'b0;
      full_reset_pulse    <= 1'b0;
      partial_reset_pulse <= 1'b0;
      config_ready        <= 1'b0;
    end else begin
      shutdown            <= in_shutdown;   // R5
      full_reset_pulse    <= full_pulse;    // R4
      partial_reset_pulse <= partial_pulse; // R4
      config_ready        <= ready_next;
    end
  end

  // Readback
  always_comb begin
    status_word                               = '0;
    status_word[ST_HW_BIT]                    = hw_mode_reg;
    status_word[ST_REF_BIT]                   = ref_sel_reg;
    status_word[ST_SEQ_BIT]                   = seq_strap_reg;
    status_word[ST_RANGE_LSB +: 2]            = range_next;
    status_word[ST_SHDN_BIT]                  = in_shutdown;
    status_word[ST_READY_BIT]                 = ready_reg;
  end

  assign rd_hit = reg_rd;

  always_comb begin
    if (hit_status)
      rd_value = status_word;
    else if (hit_control)
      rd_value = control_reg;
    else if (hit_events)
      rd_value = {{(DATA_W-EV_W){1'b0}}, events_reg};
    else if (hit_full_cnt)
      rd_value = full_cnt_reg;
    else if (hit_part_cnt)
      rd_value = part_cnt_reg;
    else
      rd_value = '0;
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      reg_rdata <= '0;
    else
      reg_rdata <= rd_hit ? rd_value : '0;
  end

endmodule : strap_latch_reset_control

// ### core/strap_pkg.sv
// Shared constants for strap latching and reset-pin decoding
package strap_pkg;

  // Clock and reset-pulse timing
  localparam int CLK_PERIOD_NS     = 40;
  localparam int T_PARTIAL_MIN_NS  = 50;
  localparam int T_FULL_MIN_NS     = 1200;
  localparam int PARTIAL_CYC       = (T_PARTIAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_CYC          = (T_FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 8;

  // Register port
  localparam int ADDR_W            = 4;
  localparam int DATA_W            = 8;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONTROL   = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_EVENTS    = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_FULL_CNT  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PART_CNT  = 4'h4;

  // STATUS fields
  localparam int ST_HW_BIT         = 0;
  localparam int ST_REF_BIT        = 1;
  localparam int ST_SEQ_BIT        = 2;
  localparam int ST_RANGE_LSB      = 3;
  localparam int ST_SHDN_BIT       = 5;
  localparam int ST_READY_BIT      = 6;

  // CONTROL fields
  localparam int CT_RANGE_LSB      = 0;
  localparam int CT_SEQ_BIT        = 2;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h03;

  // EVENTS fields, write one to clear
  localparam int EV_STRAP_BIT      = 0;
  localparam int EV_FULL_BIT       = 1;
  localparam int EV_PART_BIT       = 2;
  localparam int EV_W              = 3;

  // Mode/range select pair codes
  localparam logic [1:0] SEL_SOFTWARE = 2'h0;
  localparam logic [1:0] RANGE_2V5    = 2'h1;
  localparam logic [1:0] RANGE_5V     = 2'h2;
  localparam logic [1:0] RANGE_10V    = 2'h3;

  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_LOW} dev_state_t;

  function automatic logic is_hw_mode(input logic [1:0] pair);
    return pair != SEL_SOFTWARE;
  endfunction : is_hw_mode

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v == {CNT_W{1'b1}}) ? v : v + 8'h01;
  endfunction : sat_inc

endpackage : strap_pkg

// ### test/strap_board.sv
// Board model: reset pin pulses and strap pins
`timescale 1ns/100ps
module strap_board
  import strap_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Requests
  input  wire logic       pulse_go,
  input  wire logic [7:0] pulse_len,
  input  wire logic       ref_in,
  input  wire logic       seq_in,
  input  wire logic [1:0] pair_in,
  // Pins
  output logic            reset_pin_b,
  output logic            reference_source_select,
  output logic            sequencer_enable_strap,
  output logic            mode_range_select_hi,
  output logic            mode_range_select_lo
);
  logic [7:0] low_left_reg = 8'h00;
  logic       sw_latched_reg = 1'b0;
  assign reset_pin_b = (low_left_reg == 8'h00);
  assign reference_source_select = ref_in;
  // Software mode, pending or latched, needs the strap grounded
  assign sequencer_enable_strap = seq_in && (pair_in != 2'h0) && !sw_latched_reg;
  assign mode_range_select_hi = pair_in[1];
  assign mode_range_select_lo = pair_in[0];
  always_ff @(posedge sys_clk) begin
    if (pulse_go) low_left_reg <= pulse_len;
    else if (low_left_reg != 8'h00) low_left_reg <= low_left_reg - 8'h01;
    // A full-length pulse relatches the mode from the pair it is sent with
    if (pulse_go && pulse_len >= 8'(FULL_CYC)) sw_latched_reg <= (pair_in == 2'h0);
  end
endmodule : strap_board

// ### test/strap_latch_reset_control_sva.sv
// Port-level checker for strap latching and reset-pin decoding
`timescale 1ns/100ps
module strap_latch_reset_control_sva
  import strap_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Pins
  input wire logic       reset_pin_b,
  input wire logic       mode_range_select_hi,
  input wire logic       mode_range_select_lo,
  // Outputs watched
  input wire logic       internal_ref_enable,
  input wire logic       reference_io_pin_oe_b,
  input wire logic       sequencer_limited,
  input wire logic       sequencer_enable,
  input wire logic       hw_mode,
  input wire logic [1:0] input_range,
  input wire logic       shutdown,
  input wire logic       full_reset_pulse,
  input wire logic       partial_reset_pulse,
  input wire logic       config_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Length of the current low run, saturating so long holds never wrap
  logic [7:0] low_cnt_reg;
  logic [7:0] low_cnt_next;
  assign low_cnt_next = reset_pin_b ? 8'h00 : (&low_cnt_reg ? low_cnt_reg : low_cnt_reg + 8'h01);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_next;
  end

  property p_oe; reference_io_pin_oe_b == !internal_ref_enable; endproperty
  a_oe: assert property (p_oe) else $error("reference pin enable disagrees");
  property p_shdn; !reset_pin_b [*3] |=> shutdown; endproperty
  a_shdn: assert property (p_shdn) else $error("no shutdown while pin low");
  property p_shdn_off; shutdown |-> !internal_ref_enable && !sequencer_enable && !config_ready;
  endproperty
  a_shdn_off: assert property (p_shdn_off) else $error("active during shutdown");
  property p_full; reset_pin_b && low_cnt_reg >= FULL_CYC |-> ##[1:4] full_reset_pulse; endproperty
  a_full: assert property (p_full) else $error("long pulse not full");
  property p_part;
    reset_pin_b && low_cnt_reg >= PARTIAL_CYC && low_cnt_reg < FULL_CYC
      |-> ##[1:4] partial_reset_pulse;
  endproperty
  a_part: assert property (p_part) else $error("short pulse not partial");
  property p_glitch;
    reset_pin_b && low_cnt_reg == 8'h01 |=> (!full_reset_pulse && !partial_reset_pulse) [*4];
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch classified");
  property p_once; full_reset_pulse |-> !partial_reset_pulse ##1 !full_reset_pulse; endproperty
  a_once: assert property (p_once) else $error("full pulse malformed");
  property p_live;
    config_ready && hw_mode && {mode_range_select_hi, mode_range_select_lo} != 2'h0
      |=> input_range == $past({mode_range_select_hi, mode_range_select_lo});
  endproperty
  a_live: assert property (p_live) else $error("range not following pins");
  // Mode output moves one cycle after the full reset pulse
  property p_mode;
    $changed(hw_mode) && $past(rst_b, 4) |-> $past(full_reset_pulse);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed without full reset");
  property p_lim; sequencer_limited |-> hw_mode; endproperty
  a_lim: assert property (p_lim) else $error("limited sequencer outside hw mode");
endmodule : strap_latch_reset_control_sva

bind strap_latch_reset_control strap_latch_reset_control_sva chk (.sys_clk, .rst_b,
  .reset_pin_b, .mode_range_select_hi, .mode_range_select_lo, .internal_ref_enable,
  .reference_io_pin_oe_b, .sequencer_limited, .sequencer_enable, .hw_mode, .input_range,
  .shutdown, .full_reset_pulse, .partial_reset_pulse, .config_ready);

// ### test/strap_latch_reset_control_tb.sv
// Self-checking bench for strap latching and reset-pin decoding
`timescale 1ns/100ps
module strap_latch_reset_control_tb;
  import strap_pkg::*;
  logic              sys_clk = 1'b0, rst_b = 1'b0, pulse_go = 1'b0;
  logic [7:0]        pulse_len = 8'h00;
  logic              ref_in = 1'b1, seq_in = 1'b1;
  logic [1:0]        pair_in = 2'h2;
  logic              reset_pin_b, reference_source_select, sequencer_enable_strap;
  logic              mode_range_select_hi, mode_range_select_lo;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
  logic              reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0;
  logic              internal_ref_enable, reference_io_pin_oe_b, sequencer_enable;
  logic              sequencer_limited, hw_mode, shutdown, config_ready;
  logic              full_reset_pulse, partial_reset_pulse;
  logic [1:0]        input_range;
  logic [7:0]        exp_q[$];
  logic [31:0]       v;
  int error_cnt = 0, checks_done = 0, cyc = 0, n_full = 0, n_part = 0, seed = 32'h9cde;

  always #20 sys_clk = ~sys_clk;

  strap_board board (.sys_clk, .pulse_go, .pulse_len, .ref_in, .seq_in, .pair_in,
    .reset_pin_b, .reference_source_select, .sequencer_enable_strap, .mode_range_select_hi,
    .mode_range_select_lo);
  strap_latch_reset_control dut (.sys_clk, .rst_b, .reset_pin_b, .reference_source_select,
    .sequencer_enable_strap, .mode_range_select_hi, .mode_range_select_lo, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_ref_enable, .reference_io_pin_oe_b,
    .sequencer_enable, .sequencer_limited, .hw_mode, .input_range, .shutdown,
    .full_reset_pulse, .partial_reset_pulse, .config_ready);

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Read data is judged one cycle after the strobe, oldest note first
  always @(posedge sys_clk) begin
    rd_p <= reg_rd;
    if (rd_p && exp_q.size() > 0) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    if (full_reset_pulse === 1'b1) n_full++;
    if (partial_reset_pulse === 1'b1) n_part++;
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [7:0] len, input logic [7:0] ef, input logic [7:0] ep);
    int f0;
    int p0;
    f0 = n_full;
    p0 = n_part;
    @(posedge sys_clk);
    pulse_go <= 1'b1;
    pulse_len <= len;
    @(posedge sys_clk);
    pulse_go <= 1'b0;
    repeat (5) @(posedge sys_clk);
    if (len > 8'd8) chk("shutdown", 8'h01, 8'(shutdown));
    repeat (len + 4) @(posedge sys_clk);
    chk("full pulses", ef, 8'(n_full - f0));
    chk("partial pulses", ep, 8'(n_part - p0));
  endtask : pulse

  task automatic cfg(input logic hw, input logic [1:0] p, input logic r, input logic s);
    chk("hw_mode", 8'(hw), 8'(hw_mode));
    chk("input_range", 8'(p), 8'(input_range));
    chk("ref enable", 8'(r), 8'(internal_ref_enable));
    chk("ref oe_b", 8'(!r), 8'(reference_io_pin_oe_b));
    chk("config_ready", 8'h01, 8'(config_ready));
    if (hw) chk("seq enable", 8'(s), 8'(sequencer_enable));
    rd(OFF_STATUS, {3'h2, p, s, r, hw});
  endtask : cfg

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cfg(1'b1, 2'h2, 1'b1, 1'b1);
    chk("seq limited", 8'h01, 8'(sequencer_limited));
    for (int c = 1; c < 4; c++) begin
      pair_in <= 2'(c);
      repeat (3) @(posedge sys_clk);
      chk("live range", 8'(c), 8'(input_range));
    end
    ref_in <= 1'b0;
    seq_in <= 1'b0;
    pulse(8'h01, 8'h00, 8'h00);
    pulse(8'(PARTIAL_CYC), 8'h00, 8'h01);
    pulse(8'(FULL_CYC - 1), 8'h00, 8'h01);
    cfg(1'b1, 2'h3, 1'b1, 1'b1);
    rd(OFF_PART_CNT, 8'h02);
    pair_in <= 2'h0;
    seq_in <= 1'b1;
    pulse(8'(FULL_CYC + 10), 8'h01, 8'h00);
    cfg(1'b0, 2'h3, 1'b0, 1'b0);
    rd(OFF_CONTROL, 8'h03);
    wr(OFF_CONTROL, 8'h05);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    pair_in <= 2'h2;
    repeat (3) @(posedge sys_clk);
    cfg(1'b0, 2'h1, 1'b0, 1'b0);
    chk("sw seq enable", 8'h01, 8'(sequencer_enable));
    chk("sw seq limited", 8'h00, 8'(sequencer_limited));
    rd(OFF_CONTROL, 8'h05);
    rd(OFF_FULL_CNT, 8'h01);
    rd(OFF_EVENTS, 8'h06);
    wr(OFF_EVENTS, 8'h07);
    rd(OFF_EVENTS, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      ref_in <= v[0];
      seq_in <= v[1];
      pair_in <= (v[3:2] == 2'h0) ? 2'h1 : v[3:2];
      pulse(8'(FULL_CYC) + {3'h0, v[8:4]}, 8'h01, 8'h00);
      cfg(1'b1, pair_in, ref_in, seq_in);
    end
    repeat (3) @(posedge sys_clk);
    final_report();
  end
endmodule : strap_latch_reset_control_tb
